// ### src/aslc_ifs.sv
`timescale 1ns/1ps
interface aslc_mem_if;
   logic        we;
   logic [4:0]  waddr;
   logic [31:0] wdata;
   logic [3:0]  rd_a_slot;
   logic [63:0] rd_a_data;
   logic [4:0]  rd_b_addr;
   logic [31:0] rd_b_data;
   modport ctl (output we, waddr, wdata, rd_a_slot, rd_b_addr, input rd_a_data, rd_b_data);
   modport mem (input we, waddr, wdata, rd_a_slot, rd_b_addr, output rd_a_data, rd_b_data);
endinterface

interface aslc_led_if;
   logic [3:0][6:0] code;
   logic [3:0][6:0] grant;
   modport ctl (output code, input grant);
   modport lim (input code, output grant);
endinterface

// ### src/aslc_led_limit.sv
`timescale 1ns/1ps
`include "aslc_map.svh"
module aslc_led_limit (
   input wire logic pclk,
   input wire logic presetn,
   aslc_led_if.lim  port
);
   localparam logic [8:0] BUDGET = 9'(`ASLC_LED_BUDGET);

   aslc_pkg::aslc_led_st_type st_ff;
   aslc_pkg::aslc_led_st_type nxt_st;
   logic [8:0]                grant_sum;

   // Budget counted in code steps, so the clamp needs no multiplier
   always_comb begin
      logic [8:0] rem;
      logic [8:0] want;
      logic [8:0] give;
      rem  = BUDGET;
      want = 9'h000;
      give = 9'h000;
      nxt_st = st_ff;
      for (int i = 0; i < 4; i++) begin
         want = {2'b00, port.code[i]};
         give = (want < rem) ? want : rem; // R18
         nxt_st.grant[i] = give[6:0]; // R16
         rem = rem - give;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign port.grant = st_ff.grant;
   assign grant_sum  = 9'({2'b00, st_ff.grant[0]} + {2'b00, st_ff.grant[1]}
                        + {2'b00, st_ff.grant[2]} + {2'b00, st_ff.grant[3]});

   led_budget_a: assert property (@(posedge pclk) disable iff (!presetn) // R18
      grant_sum <= BUDGET) else $error("led grants exceed budget");
   grant_first_a: assert property (@(posedge pclk) disable iff (!presetn) // R18
      1'b1 |=> port.grant[0] == $past(port.code[0])) else $error("first driver not fully granted");
   zero_code_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
      port.code[3] == 7'h00 |=> port.grant[3] == 7'h00) else $error("zero code granted current");
endmodule

// ### src/aslc_map.svh
// How it works
// [R1] Up to twelve slots; fields apply in own slot
// [R2] Each input pair routed per slot independently
// [R3] Pair mode bit global, not per slot
// [R4] Slot route field enables pair, picks channels
// [R5] Disabled or sleeping inputs take idle bias
// [R6] Inputs active only in precondition and pulses
// [R7] Slot field selects one of seven treatments
// [R8] Precondition width per slot, default 8 us
// [R9] No bias connection while input is sampled
// [R10] Second channel off after reset, powered down
// [R11] Integration and impulse modes skip second channel; only integ_mode gates it here
// [R12] Slot enable runs second channel conversions
// [R13] Second channel words follow first channel words
// [R14] Second channel analog settings kept separately
// [R15] Four drivers per slot, one side each
// [R16] Seven-bit monotonic current code per driver
// [R17] Code zero disables driver regardless of side
// [R18] Over 400 mA, grant in driver order
// [R19] Software keeps slot total within 400 mA
// [R20] Slot fields read by executing slot index
`ifndef ASLC_MAP_SVH
`define ASLC_MAP_SVH

`define ASLC_NUM_SLOTS       4'hC
`define ASLC_NUM_WORDS       24
`define ASLC_CLK_PERIOD_NS   25
`define ASLC_CYC_PER_US      ((1000 + `ASLC_CLK_PERIOD_NS - 1) / `ASLC_CLK_PERIOD_NS)
`define ASLC_PRE_WIDTH_DEF_US 8

`define ASLC_ADDR_GLOBAL     12'h000
`define ASLC_ADDR_CH1_ANA    12'h004
`define ASLC_ADDR_CH2_ANA    12'h008
`define ASLC_ADDR_STATUS     12'h00C
`define ASLC_SLOT_BASE       12'h100
`define ASLC_SLOT_END        12'h160

`define ASLC_ROUTE_A_LSB     0
`define ASLC_ROUTE_B_LSB     3
`define ASLC_PRECON_LSB      6
`define ASLC_CH2_BIT         9
`define ASLC_PRE_WIDTH_LSB   10
`define ASLC_SIDE_LSB        18
`define ASLC_CFG_MASK        32'h03FF_FFFF
`define ASLC_LED_MASK        32'h0FFF_FFFF
// Pre width 8 us in bits 17:10
`define ASLC_CFG_RST         32'h0000_2000
`define ASLC_GLOB_RST        6'h00
`define ASLC_ANA_RST         7'h00

`define ASLC_SIDE_A          2'h1
`define ASLC_SIDE_B          2'h2
`define ASLC_LED_LIMIT_MA    400
`define ASLC_LED_STEP_UA     1600
`define ASLC_LED_BUDGET      (`ASLC_LED_LIMIT_MA * 1000 / `ASLC_LED_STEP_UA)

`endif

// ### src/aslc_pkg.sv
package aslc_pkg;
`include "aslc_map.svh"

   typedef enum logic [3:0] {
      PH_SLEEP  = 4'h1,
      PH_LOAD   = 4'h2,
      PH_PRECON = 4'h4,
      PH_SAMPLE = 4'h8
   } aslc_phase_type;

   typedef enum logic [2:0] {
      PRE_FLOAT     = 3'h0,
      PRE_BIAS_ONE  = 3'h1,
      PRE_BIAS_TWO  = 3'h2,
      PRE_IN_CM     = 3'h3,
      PRE_TIA_REF   = 3'h4,
      PRE_TIA_INPUT = 3'h5,
      PRE_SHORT     = 3'h6
   } aslc_precon_type;

   typedef struct packed {
      logic [`ASLC_NUM_WORDS-1:0][31:0] words;
      logic [63:0]                      rd_a;
      logic [31:0]                      rd_b;
   } aslc_mem_st_type;

   typedef struct packed {
      logic [3:0][6:0] grant;
   } aslc_led_st_type;

   typedef struct packed {
      aslc_phase_type  phase;
      logic [3:0]      slot;
      logic [13:0]     cnt;
      logic [31:0]     cfg;
      logic [31:0]     led;
      logic [5:0]      glob;
      logic [6:0]      ana1;
      logic [6:0]      ana2;
      logic            apb_wait;
      logic [31:0]     prdata;
      logic            ch2_pend;
      logic [31:0]     ch2_word;
      logic            fifo_wr;
      logic [31:0]     fifo_data;
      logic [1:0][2:0] route;
      logic [1:0]      idle;
      logic [1:0]      precon;
      logic            precon_region;
      logic            ch1_conv;
      logic            ch2_pwr;
      logic            ch2_conv;
      logic [3:0]      side_a;
      logic [3:0]      side_b;
   } aslc_top_st_type;
endpackage

// ### src/aslc_slot_mem.sv
`timescale 1ns/1ps
`include "aslc_map.svh"
module aslc_slot_mem (
   input wire logic pclk,
   input wire logic presetn,
   aslc_mem_if.mem  port
);
   localparam aslc_pkg::aslc_mem_st_type MEM_RST = '{
      words: {12{32'h0000_0000, `ASLC_CFG_RST}},
      rd_a:  64'h0,
      rd_b:  32'h0
   };

   aslc_pkg::aslc_mem_st_type st_ff;
   aslc_pkg::aslc_mem_st_type nxt_st;

   always_comb begin
      nxt_st = st_ff;
      if (port.we && (port.waddr < 5'(`ASLC_NUM_WORDS))) begin
         nxt_st.words[port.waddr] = port.wdata;
      end
      // Out of range slots read zero, not beyond the array
      if (port.rd_a_slot < `ASLC_NUM_SLOTS) begin
         nxt_st.rd_a = {st_ff.words[{port.rd_a_slot, 1'b1}], st_ff.words[{port.rd_a_slot, 1'b0}]};
      end else begin
         nxt_st.rd_a = 64'h0;
      end
      if (port.rd_b_addr < 5'(`ASLC_NUM_WORDS)) begin
         nxt_st.rd_b = st_ff.words[port.rd_b_addr];
      end else begin
         nxt_st.rd_b = 32'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= MEM_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign port.rd_a_data = st_ff.rd_a;
   assign port.rd_b_data = st_ff.rd_b;
endmodule

// ### src/aslc_top.sv
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "aslc_map.svh"
module aslc_top #(
   parameter int unsigned CYC_PER_US = `ASLC_CYC_PER_US
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        slot_start,
   input  wire logic [3:0]  slot_index,
   input  wire logic        slot_end,
   input  wire logic        pulse_region,
   input  wire logic        sleep_req,
   input  wire logic        integ_mode,
   input  wire logic        data_strobe,
   input  wire logic [31:0] ch1_data,
   input  wire logic [31:0] ch2_data,
   output logic             pair_a_differential_sel,
   output logic             pair_b_differential_sel,
   output logic      [1:0]  pair_a_idle_bias,
   output logic      [1:0]  pair_b_idle_bias,
   output logic      [2:0]  pair_a_slot_route,
   output logic      [2:0]  pair_b_slot_route,
   output logic             pair_a_idle,
   output logic             pair_b_idle,
   output logic             pair_a_precon,
   output logic             pair_b_precon,
   output logic      [2:0]  slot_precondition_sel,
   output logic             precon_region,
   output logic             ch1_convert_en,
   output logic             ch2_power_on,
   output logic             ch2_convert_en,
   output logic      [6:0]  ch1_analog_cfg,
   output logic      [6:0]  ch2_analog_cfg,
   output logic      [3:0]  led_side_a_on,
   output logic      [3:0]  led_side_b_on,
   output logic      [27:0] led_drive_code,
   output logic             fifo_wr,
   output logic      [31:0] fifo_data
);
   aslc_pkg::aslc_top_st_type st_ff;
   aslc_pkg::aslc_top_st_type nxt_st;
   aslc_mem_if                mem_if ();
   aslc_led_if                led_if ();
   logic                      apb_wr;
   logic                      apb_map;
   logic [31:0]               rd_val;
   logic                      ch2_act;
   logic                      in_slot;
   logic                      pulse_on;

   function automatic logic slot_hit(input logic [11:0] a);
      slot_hit = (a >= `ASLC_SLOT_BASE) && (a < `ASLC_SLOT_END) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic [4:0] slot_word(input logic [11:0] a);
      logic [11:0] off;
      off = a - `ASLC_SLOT_BASE;
      slot_word = off[6:2];
   endfunction

   function automatic logic reg_hit(input logic [11:0] a);
      reg_hit = (a == `ASLC_ADDR_GLOBAL) || (a == `ASLC_ADDR_CH1_ANA)
              || (a == `ASLC_ADDR_CH2_ANA) || (a == `ASLC_ADDR_STATUS) || slot_hit(a);
   endfunction

   aslc_slot_mem u_mem (
      .pclk    (pclk),
      .presetn (presetn),
      .port    (mem_if.mem)
   );

   aslc_led_limit u_led (
      .pclk    (pclk),
      .presetn (presetn),
      .port    (led_if.lim)
   );

   // APB: one wait state so read data come from a flop
   assign apb_map = reg_hit(paddr);
   assign pready  = penable & st_ff.apb_wait;
   assign pslverr = pready & ~apb_map;
   assign apb_wr  = psel & penable & pready & pwrite & apb_map;
   assign prdata  = st_ff.prdata;

   // Slot index steers the read port while idle, so LOAD sees the new slot
   assign mem_if.rd_a_slot = (st_ff.phase == aslc_pkg::PH_SLEEP) ? slot_index : st_ff.slot; // R20
   assign mem_if.rd_b_addr = slot_word(paddr);
   assign mem_if.we        = apb_wr & slot_hit(paddr); // R2
   assign mem_if.waddr     = slot_word(paddr);
   assign mem_if.wdata     = slot_word(paddr) % 2 == 1 ? (pwdata & `ASLC_LED_MASK) : (pwdata & `ASLC_CFG_MASK);

   // Codes straight from memory in LOAD, so grants are ready from the first precon cycle
   assign led_if.code = (st_ff.phase == aslc_pkg::PH_LOAD) ? mem_if.rd_a_data[59:32] : st_ff.led[27:0]; // R20

   assign ch2_act  = st_ff.cfg[`ASLC_CH2_BIT] & ~integ_mode; // R11 R12
   assign in_slot  = (st_ff.phase != aslc_pkg::PH_SLEEP) & ~sleep_req;
   assign pulse_on = (st_ff.phase == aslc_pkg::PH_SAMPLE) & pulse_region & ~sleep_req;

   always_comb begin
      rd_val = 32'h0000_0000;
      if (slot_hit(paddr)) begin
         rd_val = mem_if.rd_b_data;
      end else if (paddr == `ASLC_ADDR_GLOBAL) begin
         rd_val = {26'h0, st_ff.glob};
      end else if (paddr == `ASLC_ADDR_CH1_ANA) begin
         rd_val = {25'h0, st_ff.ana1};
      end else if (paddr == `ASLC_ADDR_CH2_ANA) begin
         rd_val = {25'h0, st_ff.ana2};
      end else if (paddr == `ASLC_ADDR_STATUS) begin
         rd_val = {23'h0, ch2_act, st_ff.slot, st_ff.phase};
      end
   end

   always_comb begin
      logic [7:0] width;
      logic [2:0] rt;
      logic       en;
      logic       act;
      logic [1:0] side;
      width = mem_if.rd_a_data[`ASLC_PRE_WIDTH_LSB +: 8];
      rt    = 3'h0;
      en    = 1'b0;
      act   = 1'b0;
      side  = 2'h0;
      nxt_st = st_ff;

      nxt_st.apb_wait = psel & penable & ~st_ff.apb_wait;
      if (psel && penable && !st_ff.apb_wait) begin
         nxt_st.prdata = rd_val;
      end
      if (apb_wr && paddr == `ASLC_ADDR_GLOBAL) begin
         nxt_st.glob = pwdata[5:0]; // R3
      end
      if (apb_wr && paddr == `ASLC_ADDR_CH1_ANA) begin
         nxt_st.ana1 = pwdata[6:0];
      end
      if (apb_wr && paddr == `ASLC_ADDR_CH2_ANA) begin
         nxt_st.ana2 = pwdata[6:0]; // R14
      end

      unique case (st_ff.phase)
         aslc_pkg::PH_SLEEP: begin
            if (slot_start && slot_index < `ASLC_NUM_SLOTS && !sleep_req) begin // R1
               nxt_st.slot  = slot_index;
               nxt_st.phase = aslc_pkg::PH_LOAD;
            end
         end
         aslc_pkg::PH_LOAD: begin
            nxt_st.cfg = mem_if.rd_a_data[31:0]; // R20
            nxt_st.led = mem_if.rd_a_data[63:32];
            if (width == 8'h00) begin
               nxt_st.phase = aslc_pkg::PH_SAMPLE;
            end else begin
               nxt_st.cnt   = 14'(32'(width) * CYC_PER_US - 32'd1); // R8
               nxt_st.phase = aslc_pkg::PH_PRECON;
            end
         end
         aslc_pkg::PH_PRECON: begin
            if (st_ff.cnt == 14'h0000) begin
               nxt_st.phase = aslc_pkg::PH_SAMPLE; // R8
            end else begin
               nxt_st.cnt = st_ff.cnt - 14'h0001;
            end
         end
         aslc_pkg::PH_SAMPLE: begin
            if (slot_end) begin
               nxt_st.phase = aslc_pkg::PH_SLEEP;
            end
         end
         default: begin
            nxt_st.phase = aslc_pkg::PH_SLEEP;
         end
      endcase
      // Sleep or an early slot end aborts any phase
      if (sleep_req || (slot_end && st_ff.phase != aslc_pkg::PH_SLEEP)) begin
         nxt_st.phase = aslc_pkg::PH_SLEEP; // R5
      end

      nxt_st.precon_region = in_slot & (st_ff.phase == aslc_pkg::PH_PRECON);
      nxt_st.ch1_conv      = pulse_on;
      nxt_st.ch2_pwr       = in_slot & ch2_act; // R10 R11
      nxt_st.ch2_conv      = pulse_on & ch2_act; // R12

      for (int p = 0; p < 2; p++) begin
         rt  = st_ff.cfg[3*p +: 3];
         en  = in_slot && (rt != 3'h0); // R4
         act = en && ((st_ff.phase == aslc_pkg::PH_PRECON) || pulse_on); // R6
         nxt_st.route[p]  = act ? rt : 3'h0; // R2 R4
         nxt_st.idle[p]   = ~act; // R5 R6
         nxt_st.precon[p] = en && (st_ff.phase == aslc_pkg::PH_PRECON); // R7 R9
      end

      for (int i = 0; i < 4; i++) begin
         side = st_ff.cfg[`ASLC_SIDE_LSB + 2*i +: 2];
         // Side code 3 would drive both sides, so it drives neither
         nxt_st.side_a[i] = pulse_on && side == `ASLC_SIDE_A && led_if.grant[i] != 7'h00; // R15 R17
         nxt_st.side_b[i] = pulse_on && side == `ASLC_SIDE_B && led_if.grant[i] != 7'h00; // R15 R17
      end

      // Second channel word is held one cycle behind the first
      if (data_strobe) begin
         nxt_st.fifo_wr   = 1'b1;
         nxt_st.fifo_data = ch1_data;
         nxt_st.ch2_pend  = ch2_act; // R13
         nxt_st.ch2_word  = ch2_data;
      end else if (st_ff.ch2_pend) begin
         nxt_st.fifo_wr   = 1'b1;
         nxt_st.fifo_data = st_ff.ch2_word; // R13
         nxt_st.ch2_pend  = 1'b0;
      end else begin
         nxt_st.fifo_wr = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff       <= '0;
         st_ff.phase <= aslc_pkg::PH_SLEEP;
         st_ff.glob  <= `ASLC_GLOB_RST;
         st_ff.ana1  <= `ASLC_ANA_RST;
         st_ff.ana2  <= `ASLC_ANA_RST;
         st_ff.idle  <= 2'h3;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pair_a_differential_sel = st_ff.glob[0]; // R3
   assign pair_b_differential_sel = st_ff.glob[1]; // R3
   assign pair_a_idle_bias        = st_ff.glob[3:2]; // R5
   assign pair_b_idle_bias        = st_ff.glob[5:4]; // R5
   assign pair_a_slot_route       = st_ff.route[0];
   assign pair_b_slot_route       = st_ff.route[1];
   assign pair_a_idle             = st_ff.idle[0];
   assign pair_b_idle             = st_ff.idle[1];
   assign pair_a_precon           = st_ff.precon[0];
   assign pair_b_precon           = st_ff.precon[1];
   // Reserved treatment code falls back to float
   assign slot_precondition_sel   = (st_ff.cfg[8:6] == 3'h7) ? 3'h0 : st_ff.cfg[8:6]; // R7
   assign precon_region           = st_ff.precon_region;
   assign ch1_convert_en          = st_ff.ch1_conv;
   assign ch2_power_on            = st_ff.ch2_pwr;
   assign ch2_convert_en          = st_ff.ch2_conv;
   assign ch1_analog_cfg          = st_ff.ana1;
   assign ch2_analog_cfg          = st_ff.ana2; // R14
   assign led_side_a_on           = st_ff.side_a;
   assign led_side_b_on           = st_ff.side_b;
   assign led_drive_code          = led_if.grant; // R16
   assign fifo_wr                 = st_ff.fifo_wr;
   assign fifo_data               = st_ff.fifo_data;

   ch2_off_a: assert property (@(posedge pclk) disable iff (!presetn) // R10
      (!st_ff.cfg[`ASLC_CH2_BIT] || integ_mode) |=> !ch2_power_on && !ch2_convert_en)
      else $error("second channel on while disabled");

   fifo_order_a: assert property (@(posedge pclk) disable iff (!presetn) // R13
      (data_strobe && ch2_act) |=> (fifo_wr && fifo_data == $past(ch1_data))
      ##1 (fifo_wr && fifo_data == $past(ch2_data, 2)))
      else $error("channel words out of order");

   precon_load_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
      (st_ff.phase == aslc_pkg::PH_LOAD && mem_if.rd_a_data[17:10] != 8'h00 && !sleep_req && !slot_end)
      |=> (st_ff.phase == aslc_pkg::PH_PRECON
           && st_ff.cnt == 14'(32'($past(mem_if.rd_a_data[17:10])) * CYC_PER_US - 32'd1)))
      else $error("precondition count wrong");

   precon_end_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
      (st_ff.phase == aslc_pkg::PH_PRECON && st_ff.cnt == 14'h0000 && !sleep_req && !slot_end)
      |=> st_ff.phase == aslc_pkg::PH_SAMPLE) else $error("precondition did not end");

   idle_sleep_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
      (st_ff.phase == aslc_pkg::PH_SLEEP || sleep_req) |=> (pair_a_idle && pair_b_idle
      && pair_a_slot_route == 3'h0 && !pair_a_precon)) else $error("input not idle in sleep");

   sample_bias_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
      (pulse_on && st_ff.cfg[2:0] != 3'h0) |=> (!pair_a_idle && !pair_a_precon
      && pair_a_slot_route == $past(st_ff.cfg[2:0]))) else $error("bias left on while sampling");

   slot_range_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
      (st_ff.phase == aslc_pkg::PH_SLEEP && slot_start && slot_index >= `ASLC_NUM_SLOTS)
      |=> st_ff.phase == aslc_pkg::PH_SLEEP) else $error("illegal slot started");

   mode_write_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
      (apb_wr && paddr == `ASLC_ADDR_GLOBAL) |=> (pair_a_differential_sel == $past(pwdata[0])
      && pair_b_differential_sel == $past(pwdata[1]))) else $error("pair mode not written");

   led_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // R17
      (led_if.grant[0] == 7'h00) |=> !led_side_a_on[0] && !led_side_b_on[0])
      else $error("driver on with zero code");
endmodule

// ### verification/aslc_sensor_model.sv
`timescale 1ns/1ps
module aslc_sensor_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        fire,
   output logic             data_strobe,
   output logic      [31:0] ch1_data,
   output logic      [31:0] ch2_data
);
   logic [15:0] seq_ff;
   // Data only valid with the strobe; inverted after so a late capture shows
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_ff      <= 16'h0000;
         data_strobe <= 1'b0;
         ch1_data    <= 32'h0000_0000;
         ch2_data    <= 32'h0000_0000;
      end else if (fire) begin
         seq_ff      <= seq_ff + 16'h0001;
         data_strobe <= 1'b1;
         ch1_data    <= {16'hC1C1, seq_ff + 16'h0001};
         ch2_data    <= {16'hC2C2, seq_ff + 16'h0001};
      end else begin
         data_strobe <= 1'b0;
         ch1_data    <= ~ch1_data;
         ch2_data    <= ~ch2_data;
      end
   end
endmodule

// ### verification/aslc_top_bench.sv
`timescale 1ns/1ps
module aslc_top_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, fire;
   logic        slot_start, slot_end, pulse_region, sleep_req, integ_mode, data_strobe;
   logic        pair_a_differential_sel, pair_b_differential_sel, pair_a_idle, pair_b_idle;
   logic        pair_a_precon, pair_b_precon, precon_region, ch1_convert_en, ch2_power_on;
   logic        ch2_convert_en, fifo_wr;
   logic [31:0] prdata, pwdata, ch1_data, ch2_data, fifo_data, rd;
   logic [27:0] led_drive_code;
   logic [11:0] paddr;
   logic [6:0]  ch1_analog_cfg, ch2_analog_cfg;
   logic [3:0]  slot_index, led_side_a_on, led_side_b_on;
   logic [2:0]  pair_a_slot_route, pair_b_slot_route, slot_precondition_sel;
   logic [1:0]  pair_a_idle_bias, pair_b_idle_bias;
   int          errors, num_checks, n;

   // Short microsecond keeps the precondition count visible in a few cycles
   aslc_top #(.CYC_PER_US(2)) DUT (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
      .pready, .pslverr, .slot_start, .slot_index, .slot_end, .pulse_region, .sleep_req, .integ_mode,
      .data_strobe, .ch1_data, .ch2_data, .pair_a_differential_sel, .pair_b_differential_sel,
      .pair_a_idle_bias, .pair_b_idle_bias, .pair_a_slot_route, .pair_b_slot_route, .pair_a_idle,
      .pair_b_idle, .pair_a_precon, .pair_b_precon, .slot_precondition_sel, .precon_region,
      .ch1_convert_en, .ch2_power_on, .ch2_convert_en, .ch1_analog_cfg, .ch2_analog_cfg,
      .led_side_a_on, .led_side_b_on, .led_drive_code, .fifo_wr, .fifo_data);
   aslc_sensor_model SENS (.pclk, .presetn, .fire, .data_strobe, .ch1_data, .ch2_data);

   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      // Read just after the edge: these are the values the slave sampled there
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd  = prdata;
      err = pslverr;
      if (k >= 50) errors++;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(what, rd, exp);
   endtask

   task automatic cyc(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask

   task automatic go(input logic [3:0] idx);
      @(posedge pclk);
      slot_start <= 1'b1;
      slot_index <= idx;
      @(posedge pclk);
      slot_start <= 1'b0;
   endtask

   task automatic fin;
      @(posedge pclk);
      slot_end <= 1'b1;
      @(posedge pclk);
      slot_end <= 1'b0;
   endtask

   task automatic wait_pre;
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (precon_region !== 1'b1 && n < 200);
      check("precon_region", {31'h0, precon_region}, 32'h1);
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic report_and_stop;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   initial begin
      #(25 * 5000);
      errors++;
      $display("watchdog expired");
      report_and_stop;
   end

   initial begin
      {presetn, psel, penable, pwrite, slot_start, slot_end, pulse_region, sleep_req, integ_mode, fire} = 10'h000;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      slot_index = 4'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rchk("slot5 cfg", 12'h128, 32'h0000_2000);
      rchk("slot5 codes", 12'h12C, 32'h0000_0000);
      rchk("status", 12'h00C, 32'h0000_0001);
      check("idle ch2", {30'h0, pair_a_idle, ch2_power_on}, 32'h2);
      done("reset");
      apb(1'b1, 12'h000, 32'h0000_0019);
      apb(1'b1, 12'h004, 32'h0000_0055);
      apb(1'b1, 12'h008, 32'h0000_002A);
      cyc(2);
      check("diff sel", {30'h0, pair_a_differential_sel, pair_b_differential_sel}, 32'h2);
      check("idle bias", {28'h0, pair_a_idle_bias, pair_b_idle_bias}, 32'h9);
      check("analog", {18'h0, ch1_analog_cfg, ch2_analog_cfg}, {18'h0, 7'h55, 7'h2A});
      apb(1'b0, 12'h010, 32'h0000_0000);
      check("unmapped", {err, rd[30:0]}, 32'h8000_0000);
      done("registers");
      apb(1'b1, 12'h128, 32'h0164_0703);
      apb(1'b1, 12'h12C, {4'h0, 7'h00, 7'h64, 7'h64, 7'h64});
      rchk("cfg back", 12'h128, 32'h0164_0703);
      go(4'h5);
      wait_pre;
      check("precon sel", {29'h0, slot_precondition_sel}, 32'h4);
      check("route", {26'h0, pair_a_slot_route, pair_b_slot_route}, 32'h18);
      check("precon idle", {28'h0, pair_a_idle, pair_a_precon, pair_b_idle, pair_b_precon}, 32'h6);
      n = 1;
      while (precon_region === 1'b1 && n < 100) begin
         cyc(1);
         n++;
      end
      check("precon length", n - 1, 32'h2);
      @(posedge pclk);
      pulse_region <= 1'b1;
      cyc(3);
      check("convert", {29'h0, ch1_convert_en, ch2_convert_en, ch2_power_on}, 32'h7);
      check("sample bias", {28'h0, pair_a_idle, pair_a_precon, pair_b_idle, pair_b_precon}, 32'h2);
      check("side", {24'h0, led_side_a_on, led_side_b_on}, 32'h52);
      check("drive", {4'h0, led_drive_code}, {4'h0, 7'h00, 7'h32, 7'h64, 7'h64});
      rchk("status", 12'h00C, 32'h0000_0158);
      @(posedge pclk);
      fire <= 1'b1;
      @(posedge pclk);
      fire <= 1'b0;
      n = 0;
      do begin
         cyc(1);
         n++;
      end while (fifo_wr !== 1'b1 && n < 20);
      check("fifo first", fifo_data, 32'hC1C1_0001);
      cyc(1);
      check("fifo second", {fifo_wr, fifo_data[30:0]}, 32'hC2C2_0001);
      @(posedge pclk);
      integ_mode <= 1'b1;
      cyc(3);
      check("integ ch2", {30'h0, ch2_power_on, ch2_convert_en}, 32'h0);
      @(posedge pclk);
      integ_mode <= 1'b0;
      pulse_region <= 1'b0;
      cyc(3);
      check("between pulses", {28'h0, pair_a_idle, pair_a_slot_route}, 32'h8);
      fin;
      cyc(3);
      check("after slot", {30'h0, pair_a_idle, ch2_power_on}, 32'h2);
      done("slot");
      go(4'hC);
      cyc(3);
      apb(1'b0, 12'h00C, 32'h0000_0000);
      check("index 12", {28'h0, rd[3:0]}, 32'h1);
      apb(1'b1, 12'h104, {4'h0, 7'h00, 7'h00, 7'h28, 7'h50});
      go(4'h0);
      wait_pre;
      check("slot0", {27'h0, pair_a_slot_route, pair_a_idle, ch2_power_on}, 32'h2);
      check("slot0 drive", {4'h0, led_drive_code}, {4'h0, 7'h00, 7'h00, 7'h28, 7'h50});
      @(posedge pclk);
      sleep_req <= 1'b1;
      cyc(3);
      check("sleep", {30'h0, precon_region, pair_a_idle}, 32'h1);
      @(posedge pclk);
      sleep_req <= 1'b0;
      done("slots");
      report_and_stop;
   end
endmodule
